//--- core/acrb_config_bank.sv
// ---------------------------------------------------------------------------
// acrb_config_bank : converter configuration registers behind an apb slave,
// with the test-pattern / format stage on the sample path
// ---------------------------------------------------------------------------
// assumes samples arrive on pclk with a one-cycle valid strobe; the format
// select pin is asynchronous and is synchronised here
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps

// Contract
// - bit0 power reg: low-rate mode select
// - bit7 power reg: global power down
// - bit3: twos complement or offset binary
// - pattern 000 normal, 001 zeros, 010 ones
// - pattern 011 alternating toggle, inverts each word
// - pattern 100 ramp wraps at ffff
// - pattern 101 outputs user word
// - gain codes 1000..1110 map 0..6 dB
// - gain resets to code 1001
// - register 69 gives user bits 7..0
// - register 6a gives user bits 15..8
// - style reset value: pin chooses interface
// - style 01 forces ddr lvds
// - style 11 forces parallel cmos
// - reference bit4 selects external reference
// - writing 1 to 6e bit0 restores defaults
// - driver current field, 00 default
// - clock termination field, 000 off
// - data termination field, same encoding
// - current multiplier field per code
// - one write updates several fields
module acrb_config_bank
   import acrb_pkg::*;
(
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire acrb_pkg::acrb_apb_req_t apb_req,
   output acrb_pkg::acrb_apb_rsp_t      apb_rsp,
   input  wire logic                    format_select_pin,
   input  wire logic [15:0]             sample_in,
   input  wire logic                    sample_in_valid,
   output logic [15:0]                  sample_out,
   output logic                         sample_out_valid,
   output acrb_pkg::acrb_ctrl_t         ctrl
);
   import acrb_pkg::*;

   // -----------------------------------------------------------------------
   // state
   // -----------------------------------------------------------------------
   typedef struct packed {
      acrb_regs_t    regs;
      logic          pin_meta;
      logic          pin_sync;
      logic [15:0]   ramp;
      logic [15:0]   toggle;
      logic [15:0]   out_word;
      logic          out_valid;
      acrb_apb_rsp_t rsp;
      acrb_ctrl_t    ctrl;
   } acrb_state_t;

   acrb_state_t state_reg;
   acrb_state_t state_next;

   localparam acrb_regs_t REGS_DEFAULT = '{
      power_and_speed_control:   RST_ZERO,
      test_pattern_select:       RST_ZERO,
      fine_amplification:        RST_FINE_AMP,
      user_pattern_low:          RST_ZERO,
      user_pattern_high:         RST_ZERO,
      output_style_control:      RST_ZERO,
      bias_source_control:       RST_ZERO,
      line_driver_setup:         RST_ZERO,
      driver_current_multiplier: RST_ZERO
   };

   localparam acrb_state_t STATE_RESET = '{
      regs:      REGS_DEFAULT,
      pin_meta:  1'b0,
      pin_sync:  1'b0,
      ramp:      WORD_ZERO,
      toggle:    TOGGLE_SEED,
      out_word:  WORD_ZERO,
      out_valid: 1'b0,
      rsp:       '0,
      ctrl:      '0
   };

   // -----------------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------------
   // gain code to dB; top bit clear acts as 1 dB
   function automatic logic [2:0] gain_of(input logic [7:0] r);
      if (!r[GAIN_MSB_BIT]) begin
         gain_of = GAIN_ONE_DB;
      end else begin
         gain_of = r[2:0];
      end
   endfunction

   function automatic logic [7:0] read_of(input acrb_regs_t g, input logic [7:0] idx);
      case (idx)
         IDX_POWER_SPEED:  read_of = g.power_and_speed_control;
         IDX_TEST_PATTERN: read_of = g.test_pattern_select;
         IDX_FINE_AMP:     read_of = g.fine_amplification;
         IDX_USER_LOW:     read_of = g.user_pattern_low;
         IDX_USER_HIGH:    read_of = g.user_pattern_high;
         IDX_OUT_STYLE:    read_of = g.output_style_control;
         IDX_BIAS_SOURCE:  read_of = g.bias_source_control;
         IDX_LINE_DRIVER:  read_of = g.line_driver_setup;
         IDX_CURR_MULT:    read_of = g.driver_current_multiplier;
         default:          read_of = RST_ZERO;
      endcase
   endfunction

   function automatic logic mapped(input logic [7:0] idx);
      mapped = (idx == IDX_POWER_SPEED) || (idx == IDX_TEST_PATTERN) || (idx == IDX_FINE_AMP) ||
               (idx == IDX_USER_LOW) || (idx == IDX_USER_HIGH) || (idx == IDX_OUT_STYLE) ||
               (idx == IDX_BIAS_SOURCE) || (idx == IDX_REG_CLEAR) || (idx == IDX_LINE_DRIVER) ||
               (idx == IDX_CURR_MULT);
   endfunction

   // -----------------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------------
   always_comb begin
      logic [7:0]    idx;
      logic [7:0]    wb;
      logic          setup;
      logic [15:0]   word;
      logic [15:0]   user;
      acrb_pattern_t pat;
      acrb_style_t   style;
      acrb_regs_t    r;

      state_next = state_reg;
      idx        = apb_req.paddr[ADDR_W-1:ADDR_LSB];
      wb         = apb_req.pwdata[7:0];
      setup      = apb_req.psel && !apb_req.penable;
      word       = WORD_ZERO;
      user       = WORD_ZERO;
      pat        = PAT_NORMAL;
      style      = STYLE_PIN;
      r          = state_reg.regs;

      // pin crosses in through two flops; only the second is used
      state_next.pin_meta = format_select_pin;
      state_next.pin_sync = state_reg.pin_meta;

      // zero-wait slave: answer in the access cycle right after setup
      state_next.rsp.pready  = setup;
      state_next.rsp.pslverr = setup && !mapped(idx);
      state_next.rsp.prdata  = RDATA_ZERO;
      if (setup && !apb_req.pwrite) begin
         state_next.rsp.prdata = {24'h00_0000, read_of(state_reg.regs, idx)};
      end

      // write lands at the access-phase edge, whole byte at once
      if (apb_req.psel && apb_req.penable && apb_req.pwrite && state_reg.rsp.pready) begin
         case (idx)
            IDX_POWER_SPEED:  state_next.regs.power_and_speed_control   = wb;
            IDX_TEST_PATTERN: state_next.regs.test_pattern_select       = wb;
            IDX_FINE_AMP:     state_next.regs.fine_amplification        = wb;
            IDX_USER_LOW:     state_next.regs.user_pattern_low          = wb;
            IDX_USER_HIGH:    state_next.regs.user_pattern_high         = wb;
            IDX_OUT_STYLE:    state_next.regs.output_style_control      = wb;
            IDX_BIAS_SOURCE:  state_next.regs.bias_source_control       = wb;
            IDX_LINE_DRIVER:  state_next.regs.line_driver_setup         = wb;
            IDX_CURR_MULT:    state_next.regs.driver_current_multiplier = wb;
            IDX_REG_CLEAR: begin
               if (wb[CLEAR_BIT]) begin
                  state_next.regs = REGS_DEFAULT;
               end
            end
            default: begin
            end
         endcase
      end

      // controls are taken from the next register state, so they update at the same edge as the registers
      r     = state_next.regs;
      pat   = acrb_pattern_t'(r.test_pattern_select[PATTERN_LSB +: 3]);
      style = acrb_style_t'(r.output_style_control[STYLE_LSB +: 2]);
      state_next.ctrl.global_power_down  = r.power_and_speed_control[POWER_DOWN_BIT];
      state_next.ctrl.low_rate_mode      = r.power_and_speed_control[LOW_RATE_BIT];
      state_next.ctrl.external_reference = r.bias_source_control[EXT_REF_BIT];
      state_next.ctrl.gain_db            = gain_of(r.fine_amplification);
      state_next.ctrl.drive_current      = r.line_driver_setup[CURR_LSB +: 2];
      state_next.ctrl.clk_termination    = r.line_driver_setup[CLK_TERM_LSB +: 3];
      state_next.ctrl.data_termination   = r.line_driver_setup[DATA_TERM_LSB +: 3];
      // multiplier: data doubles for 01 and 11; clock x2 for 01/10, x4 for 11
      state_next.ctrl.data_current_double = r.driver_current_multiplier[MULT_LSB];
      state_next.ctrl.clk_current_mult    = r.driver_current_multiplier[MULT_LSB +: 2];
      case (style)
         STYLE_LVDS: state_next.ctrl.lvds_selected = 1'b1;
         STYLE_CMOS: state_next.ctrl.lvds_selected = 1'b0;
         default:    state_next.ctrl.lvds_selected = state_reg.pin_sync;
      endcase

      // sample path; power-down parks the outputs low
      user = {r.user_pattern_high, r.user_pattern_low};
      state_next.out_valid = sample_in_valid && !state_next.ctrl.global_power_down;
      if (sample_in_valid) begin
         case (pat)
            PAT_NORMAL: begin
               word = sample_in;
               if (r.power_and_speed_control[NUM_FORMAT_BIT]) begin
                  word = sample_in ^ SIGN_FLIP;
               end
            end
            PAT_ZEROS:  word = WORD_ZERO;
            PAT_ONES:   word = WORD_ONES;
            PAT_TOGGLE: word = state_reg.toggle;
            PAT_RAMP:   word = state_reg.ramp;
            PAT_USER:   word = user;
            default:    word = WORD_ZERO;
         endcase
         state_next.toggle = ~state_reg.toggle;
         state_next.ramp   = state_reg.ramp + RAMP_STEP;
         if (pat != PAT_RAMP) begin
            state_next.ramp = WORD_ZERO;
         end
         if (pat != PAT_TOGGLE) begin
            state_next.toggle = TOGGLE_SEED;
         end
         state_next.out_word = state_next.ctrl.global_power_down ? WORD_ZERO : word;
      end else if (state_next.ctrl.global_power_down) begin
         state_next.out_word = WORD_ZERO;
      end
   end

   // -----------------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= STATE_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign apb_rsp          = state_reg.rsp;
   assign sample_out       = state_reg.out_word;
   assign sample_out_valid = state_reg.out_valid;
   assign ctrl             = state_reg.ctrl;

endmodule

//--- core/acrb_pkg.sv
// ---------------------------------------------------------------------------
// acrb_pkg : register map, field layout, reset values and carrier structs
// ---------------------------------------------------------------------------
// assumes an apb slave with 32-bit data; registers sit in the low byte
package acrb_pkg;

   // -----------------------------------------------------------------------
   // register indices and byte addresses
   // -----------------------------------------------------------------------
   localparam logic [7:0] IDX_POWER_SPEED  = 8'h63;
   localparam logic [7:0] IDX_TEST_PATTERN = 8'h65;
   localparam logic [7:0] IDX_FINE_AMP     = 8'h68;
   localparam logic [7:0] IDX_USER_LOW     = 8'h69;
   localparam logic [7:0] IDX_USER_HIGH    = 8'h6a;
   localparam logic [7:0] IDX_OUT_STYLE    = 8'h6c;
   localparam logic [7:0] IDX_BIAS_SOURCE  = 8'h6d;
   localparam logic [7:0] IDX_REG_CLEAR    = 8'h6e;
   localparam logic [7:0] IDX_LINE_DRIVER  = 8'h7e;
   localparam logic [7:0] IDX_CURR_MULT    = 8'h7f;
   localparam int         ADDR_W           = 10;
   localparam int         ADDR_LSB         = 2;

   // -----------------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------------
   localparam int LOW_RATE_BIT    = 0;
   localparam int NUM_FORMAT_BIT  = 3;
   localparam int POWER_DOWN_BIT  = 7;
   localparam int PATTERN_LSB     = 5;
   localparam int GAIN_MSB_BIT    = 3;
   localparam int STYLE_LSB       = 3;
   localparam int EXT_REF_BIT     = 4;
   localparam int CLEAR_BIT       = 0;
   localparam int CURR_LSB        = 0;
   localparam int CLK_TERM_LSB    = 2;
   localparam int DATA_TERM_LSB   = 5;
   localparam int MULT_LSB        = 6;

   // -----------------------------------------------------------------------
   // reset values and codes
   // -----------------------------------------------------------------------
   localparam logic [7:0]  RST_ZERO       = 8'h00;
   localparam logic [7:0]  RST_FINE_AMP   = 8'h09;
   localparam logic [3:0]  GAIN_ZERO_DB   = 4'h8;
   localparam logic [2:0]  GAIN_ONE_DB    = 3'h1;
   localparam logic [15:0] WORD_ZERO      = 16'h0000;
   localparam logic [15:0] WORD_ONES      = 16'hffff;
   localparam logic [15:0] TOGGLE_SEED    = 16'h5555;
   localparam logic [15:0] RAMP_STEP      = 16'h0001;
   localparam logic [15:0] SIGN_FLIP      = 16'h8000;
   localparam logic [31:0] RDATA_ZERO     = 32'h0000_0000;

   typedef enum logic [2:0] {
      PAT_NORMAL = 3'h0,
      PAT_ZEROS  = 3'h1,
      PAT_ONES   = 3'h2,
      PAT_TOGGLE = 3'h3,
      PAT_RAMP   = 3'h4,
      PAT_USER   = 3'h5
   } acrb_pattern_t;

   typedef enum logic [1:0] {
      STYLE_PIN  = 2'h0,
      STYLE_LVDS = 2'h1,
      STYLE_PIN2 = 2'h2,
      STYLE_CMOS = 2'h3
   } acrb_style_t;

   // -----------------------------------------------------------------------
   // carriers
   // -----------------------------------------------------------------------
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } acrb_apb_req_t;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } acrb_apb_rsp_t;

   typedef struct packed {
      logic        global_power_down;
      logic        low_rate_mode;
      logic        external_reference;
      logic        lvds_selected;
      logic [2:0]  clk_termination;
      logic [2:0]  data_termination;
      logic [1:0]  drive_current;
      logic [1:0]  clk_current_mult;
      logic        data_current_double;
      logic [2:0]  gain_db;
   } acrb_ctrl_t;

   typedef struct packed {
      logic [7:0] power_and_speed_control;
      logic [7:0] test_pattern_select;
      logic [7:0] fine_amplification;
      logic [7:0] user_pattern_low;
      logic [7:0] user_pattern_high;
      logic [7:0] output_style_control;
      logic [7:0] bias_source_control;
      logic [7:0] line_driver_setup;
      logic [7:0] driver_current_multiplier;
   } acrb_regs_t;

endpackage

//--- verif/acrb_properties.sv
// concurrent checks on the configuration bank ports
// assumes it is bound onto acrb_config_bank, one pclk domain
`timescale 1ns/10ps
module acrb_props
   import acrb_pkg::*;
(
   input wire logic                    pclk,
   input wire logic                    presetn,
   input wire acrb_pkg::acrb_apb_req_t apb_req,
   input wire acrb_pkg::acrb_apb_rsp_t apb_rsp,
   input wire logic                    sample_in_valid,
   input wire logic                    sample_out_valid,
   input wire acrb_pkg::acrb_ctrl_t    ctrl
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ---------------------
   // register bus
   // ---------------------
   chk_ready_after_setup: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
      else $error("no zero-wait pready after setup");
   chk_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("pready held longer than one cycle");
   chk_ready_in_access: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
      else $error("pready outside access phase");
   chk_error_with_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
      else $error("pslverr without pready");
   chk_rdata_idle: assert property (!(apb_rsp.pready && !apb_req.pwrite) |-> apb_rsp.prdata == RDATA_ZERO)
      else $error("read data not zero outside a read");
   chk_rdata_byte_only: assert property (apb_rsp.prdata[31:8] == 24'h00_0000)
      else $error("read data above the low byte");
   // ---------------------
   // sample path and controls
   // ---------------------
   chk_out_valid_cause: assert property (sample_out_valid |-> $past(sample_in_valid))
      else $error("output valid without an input sample");
   chk_powerdown_quiet: assert property (ctrl.global_power_down |-> !sample_out_valid)
      else $error("sample emitted while powered down");
   chk_gain_range: assert property (ctrl.gain_db <= 3'd6)
      else $error("gain above six steps");
   cov_error: cover property (apb_rsp.pslverr);
   cov_stream: cover property (sample_out_valid ##1 sample_out_valid);
   cov_lvds: cover property ($rose(ctrl.lvds_selected));
endmodule

bind acrb_config_bank acrb_props chk_u (.pclk, .presetn, .apb_req, .apb_rsp, .sample_in_valid, .sample_out_valid, .ctrl);

//--- verif/acrb_host_model.sv
// host side of the configuration port: an apb master
// assumes the bank answers with pready; the bench timeout cuts a hang
`timescale 1ns/10ps
module acrb_host_model
   import acrb_pkg::*;
(
   input  wire logic                    pclk,
   output acrb_pkg::acrb_apb_req_t      apb_req,
   input  wire acrb_pkg::acrb_apb_rsp_t apb_rsp
);
   initial apb_req = '0;
   // ---------------------
   // one transfer, held until pready is seen at an edge
   // ---------------------
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd, output logic err);
      @(posedge pclk);
      apb_req <= '{1'b1, 1'b0, w, {idx, 2'b00}, {24'h00_0000, wd}};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
      rd = apb_rsp.prdata[7:0];
      err = apb_rsp.pslverr;
      apb_req <= '0;
   endtask
endmodule

//--- verif/test_adc_config_register_bank.sv
// self-checking bench for the configuration bank
// assumes acrb_host_model drives the bus and the checker is bound
`timescale 1ns/10ps
module test_adc_config_register_bank;
   import acrb_pkg::*;
   logic          pclk;
   logic          presetn;
   logic          format_select_pin;
   logic [15:0]   sample_in;
   logic          sample_in_valid;
   logic [15:0]   sample_out;
   logic          sample_out_valid;
   acrb_apb_req_t apb_req;
   acrb_apb_rsp_t apb_rsp;
   acrb_ctrl_t    ctrl;
   logic [7:0]    rd;
   logic          err;
   int            failures = 0;
   int            samples_checked = 0;
   int            cycles = 0;
   logic [7:0]    idx_tab [10] = '{IDX_POWER_SPEED, IDX_TEST_PATTERN, IDX_FINE_AMP, IDX_USER_LOW, IDX_USER_HIGH,
                                   IDX_OUT_STYLE, IDX_BIAS_SOURCE, IDX_LINE_DRIVER, IDX_CURR_MULT, IDX_REG_CLEAR};
   logic [7:0]    val_tab [9]  = '{8'h89, 8'ha0, 8'h0c, 8'hcd, 8'hab, 8'h08, 8'h10, 8'he6, 8'h80};

   acrb_config_bank dut_u (.pclk, .presetn, .apb_req, .apb_rsp, .format_select_pin, .sample_in,
                           .sample_in_valid, .sample_out, .sample_out_valid, .ctrl);
   acrb_host_model host_u (.pclk, .apb_req, .apb_rsp);

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // ---------------------
   // helpers
   // ---------------------
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      host_u.xfer(1'b1, idx, d, rd, err);
   endtask
   task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input logic exp_err);
      host_u.xfer(1'b0, idx, 8'h00, rd, err);
      cmp(32'(rd), 32'(exp));
      cmp(32'(err), 32'(exp_err));
   endtask
   task automatic tick;
      @(posedge pclk);
      #1;
   endtask
   // one sample in, its formatted word checked a cycle later
   task automatic smp(input logic [15:0] d, input logic [15:0] exp, input logic v);
      @(posedge pclk);
      sample_in <= d;
      sample_in_valid <= 1'b1;
      @(posedge pclk);
      sample_in_valid <= 1'b0;
      #1;
      cmp(32'(sample_out_valid), 32'(v));
      if (v) cmp(32'(sample_out), 32'(exp));
   endtask
   task automatic defaults;
      foreach (idx_tab[i]) rdc(idx_tab[i], (idx_tab[i] == IDX_FINE_AMP) ? RST_FINE_AMP : RST_ZERO, 1'b0);
      cmp(32'(ctrl), 32'h0000_0001);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ramp wrap needs 65536 samples; ceiling leaves some margin
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 70000) begin
         failures++;
         end_of_test;
      end
   end
   // ---------------------
   // tests
   // ---------------------
   initial begin
      presetn = 1'b0;
      format_select_pin = 1'b0;
      sample_in = 16'h0000;
      sample_in_valid = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      tick;
      cmp(32'(ctrl.gain_db), 32'h0000_0001);
      defaults;
      $display("test reset values done");
      foreach (val_tab[i]) wr(idx_tab[i], val_tab[i]);
      foreach (val_tab[i]) rdc(idx_tab[i], val_tab[i], 1'b0);
      rdc(8'h70, 8'h00, 1'b1);
      cmp(32'(ctrl), 32'({4'hf, 3'd1, 3'd7, 2'd2, 2'd2, 1'b0, 3'd4}));
      smp(16'h1234, 16'h0000, 1'b0);
      $display("test register access done");
      wr(IDX_REG_CLEAR, 8'h01);
      defaults;
      $display("test software clear done");
      for (int c = 0; c < 15; c++) begin
         wr(IDX_FINE_AMP, 8'(c));
         tick;
         cmp(32'(ctrl.gain_db), c[3] ? 32'(c - 8) : 32'h0000_0001);
      end
      for (int s = 0; s < 8; s++) begin
         @(posedge pclk);
         format_select_pin <= s[0];
         wr(IDX_OUT_STYLE, {3'b000, s[2:1], 3'b000});
         repeat (3) tick;
         cmp(32'(ctrl.lvds_selected), (s[2:1] == 2'd1) ? 32'h1 : (s[2:1] == 2'd3) ? 32'h0 : 32'(s[0]));
      end
      $display("test gain and style done");
      smp(16'h1234, 16'h1234, 1'b1);
      wr(IDX_POWER_SPEED, 8'h08);
      smp(16'h1234, 16'h9234, 1'b1);
      wr(IDX_POWER_SPEED, 8'h00);
      wr(IDX_TEST_PATTERN, 8'h20);
      smp(16'hffff, WORD_ZERO, 1'b1);
      wr(IDX_TEST_PATTERN, 8'h40);
      smp(16'h0000, WORD_ONES, 1'b1);
      wr(IDX_TEST_PATTERN, 8'h60);
      smp(16'h0000, 16'h5555, 1'b1);
      smp(16'h0000, 16'haaaa, 1'b1);
      wr(IDX_USER_LOW, 8'hcd);
      wr(IDX_USER_HIGH, 8'hab);
      wr(IDX_TEST_PATTERN, 8'ha0);
      smp(16'h0000, 16'habcd, 1'b1);
      wr(IDX_TEST_PATTERN, 8'h80);
      sample_in_valid <= 1'b1;
      for (int i = 0; i < 65538; i++) begin
         tick;
         cmp(32'(sample_out), 32'(i[15:0]));
      end
      @(posedge pclk);
      sample_in_valid <= 1'b0;
      $display("test_pattern_select done");
      end_of_test;
   end
endmodule
